// *** light_curtain_mode_control.sv ***
// mode, safety output and indicator controller of a light curtain receiver
//
// Behaviour
// - power-up self-test and configuration read precede any operation
// - fault at power-up: no scanning, outputs off, diagnostics displayed
// - no fault: enter alignment mode and search for the sync pattern
// - aligned with valid sync: enter run mode, no manual reset needed
// - run mode, any beam blocked: safety outputs off within response time
// - run mode, all beams clear again: outputs back on automatically
// - fault while running: stop scanning, outputs off, lockout with diagnostics
// - emitter lamp: single red flash at power-up, green run, flashing red lockout
// - show scan code three times at power-up and on change; lockout shows error
// - status lamp green outputs on, red outputs off, flashing red lockout
// - amber lamp on in run mode, off in power-up, alignment, lockout
// - eight zone lamps, each reporting one eighth of the beams
// - zone lamp green when clear, red when any beam in it blocked
// - alignment with beam 1 blocked: zone 1 red, others off, outputs off
// - alignment or run blocked: display blocked count, outputs off
// - run all clear: status green, all zones green, outputs on
// - lockout: zones and amber off, status flashing red, error shown
// - reduced resolution enabled: run clear status lamp flashes green
// - lockout left only by power cycle
//
// The placing of the registers and strobed register access were chosen for this implementation.
`include "lc_defines.svh"
module light_curtain_mode_control #(
    parameter int FLASH_CYCLES = `FLASH_HALF_MS * (`CLK_HZ / 1000),
    parameter int SELFTEST_CYCLES = `SELFTEST_MS * (`CLK_HZ / 1000),
    parameter int DIGIT_CYCLES = `DIGIT_MS * (`CLK_HZ / 1000)
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // optical scan and diagnostics, asynchronous
    input wire logic [`NUM_BEAMS-1:0] i_beam_blocked,
    input wire logic i_sync_valid,
    input wire logic i_fault,
    input wire logic [7:0] i_fault_code,
    // safety outputs
    output logic [1:0] o_safety_output_pair,
    // indicators
    output logic o_emit_red,
    output logic o_emit_green,
    output logic o_status_red,
    output logic o_status_green,
    output logic o_reset_lamp,
    output logic [`NUM_ZONES-1:0] o_zone_red,
    output logic [`NUM_ZONES-1:0] o_zone_green,
    output lc_types_pkg::seg_type o_seg_hi,
    output lc_types_pkg::seg_type o_seg_lo
);
    import lc_types_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic seg_type hex_seg(input logic [3:0] v);
        case (v)
            4'h0: hex_seg = 7'h3F;
            4'h1: hex_seg = 7'h06;
            4'h2: hex_seg = 7'h5B;
            4'h3: hex_seg = 7'h4F;
            4'h4: hex_seg = 7'h66;
            4'h5: hex_seg = 7'h6D;
            4'h6: hex_seg = 7'h7D;
            4'h7: hex_seg = 7'h07;
            4'h8: hex_seg = 7'h7F;
            4'h9: hex_seg = 7'h6F;
            4'hA: hex_seg = 7'h77;
            4'hB: hex_seg = 7'h7C;
            4'hC: hex_seg = 7'h39;
            4'hD: hex_seg = 7'h5E;
            4'hE: hex_seg = 7'h79;
            default: hex_seg = 7'h71;
        endcase
    endfunction

    function automatic logic [4:0] count_ones(input logic [`NUM_BEAMS-1:0] v);
        logic [4:0] n;
        n = 5'h0;
        for (int i = 0; i < `NUM_BEAMS; i++) begin
            n = n + {4'h0, v[i]};
        end
        count_ones = n;
    endfunction

    // ****************************************
    // reset release and input synchronisers
    // ****************************************
    logic [1:0] rst_pipe_reg;
    logic rst_sync_n;
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_reg[1];

    logic [`NUM_BEAMS+9:0] in_meta_reg;
    logic [`NUM_BEAMS+9:0] in_sync_reg;
    always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            in_meta_reg <= '0;
            in_sync_reg <= '0;
        end else begin
            in_meta_reg <= {i_fault_code, i_fault, i_sync_valid, i_beam_blocked};
            in_sync_reg <= in_meta_reg;
        end
    end

    wire [`NUM_BEAMS-1:0] beam_s = in_sync_reg[`NUM_BEAMS-1:0];
    wire sync_s = in_sync_reg[`NUM_BEAMS];
    wire fault_s = in_sync_reg[`NUM_BEAMS+1];
    wire [7:0] code_s = in_sync_reg[`NUM_BEAMS+9:`NUM_BEAMS+2];
    wire blk_any = |beam_s;
    wire [4:0] blk_count = count_ones(beam_s);

    // ****************************************
    // register port
    // ****************************************
    logic redres_reg;
    logic [3:0] scan_reg;
    logic [7:0] err_reg;
    mode_type mode_reg;
    logic safe_on_reg;

    wire wr_ctrl = i_wr && (i_addr == `REG_CTRL);
    wire [3:0] scan_new = i_wdata[`CTRL_SCAN_LSB +: `CTRL_SCAN_W];
    wire scan_changed = wr_ctrl && (scan_new != scan_reg);
    wire [31:0] ctrl_view = {24'h0, scan_reg, 3'h0, redres_reg};
    wire [31:0] status_view = {19'h0, blk_count, 5'h0, safe_on_reg, mode_reg};
    wire [31:0] rd_mux = (i_addr == `REG_CTRL) ? ctrl_view :
                         (i_addr == `REG_STATUS) ? status_view :
                         (i_addr == `REG_ERR) ? {24'h0, err_reg} : 32'h0;

    always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            redres_reg <= 1'b0;
            scan_reg <= `SCAN_RESET;
            o_rdata <= 32'h0;
        end else begin
            if (wr_ctrl) begin
                redres_reg <= i_wdata[`CTRL_REDRES_BIT];
                scan_reg <= scan_new;
            end
            o_rdata <= i_rd ? rd_mux : 32'h0;
        end
    end

    // ****************************************
    // timers
    // ****************************************
    logic [31:0] flash_cnt_reg;
    logic flash_reg;
    logic [31:0] st_cnt_reg;
    logic first_reg;
    wire st_done = (st_cnt_reg == 32'(SELFTEST_CYCLES - 1));
    // single power-up flash: lit in the first half of the self-test
    wire st_flash = (st_cnt_reg < 32'(SELFTEST_CYCLES / 2));

    always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flash_cnt_reg <= 32'h0;
            flash_reg <= 1'b0;
            st_cnt_reg <= 32'h0;
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
            if (flash_cnt_reg == 32'(FLASH_CYCLES - 1)) begin
                flash_cnt_reg <= 32'h0;
                flash_reg <= !flash_reg;
            end else begin
                flash_cnt_reg <= flash_cnt_reg + 32'h1;
            end
            if (mode_reg == ST_SELFTEST && !st_done) begin
                st_cnt_reg <= st_cnt_reg + 32'h1;
            end
        end
    end

    // ****************************************
    // mode control and safety outputs
    // ****************************************
    mode_type mode_next;
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            ST_SELFTEST: begin
                if (st_done) begin
                    mode_next = fault_s ? ST_LOCKOUT : ST_ALIGN;
                end
            end
            ST_ALIGN: begin
                if (fault_s) begin
                    mode_next = ST_LOCKOUT;
                end else if (sync_s && !blk_any) begin
                    mode_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (fault_s) begin
                    mode_next = ST_LOCKOUT;
                end
            end
            ST_LOCKOUT: mode_next = ST_LOCKOUT;
            default: mode_next = ST_LOCKOUT;
        endcase
    end

    // outputs on only in run mode with every beam clear and no fault
    wire safe_next = (mode_reg == ST_RUN) && !blk_any && !fault_s;

    always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_reg <= ST_SELFTEST;
            safe_on_reg <= 1'b0;
            o_safety_output_pair <= 2'h0;
            err_reg <= 8'h0;
        end else begin
            mode_reg <= mode_next;
            safe_on_reg <= safe_next;
            o_safety_output_pair <= {safe_next, safe_next};
            if (mode_reg != ST_LOCKOUT && mode_next == ST_LOCKOUT) begin
                err_reg <= code_s;
            end
        end
    end

    // ****************************************
    // indicators
    // ****************************************
    logic show_busy;
    logic show_lit;
    scan_code_show #(
        .DIGIT_CYCLES(DIGIT_CYCLES)
    ) u_show (
        .i_core_clk(i_core_clk),
        .i_rst_sync_n(rst_sync_n),
        .i_start(first_reg || scan_changed),
        .o_busy(show_busy),
        .o_lit(show_lit)
    );

    wire in_st = (mode_reg == ST_SELFTEST);
    wire in_align = (mode_reg == ST_ALIGN);
    wire in_run = (mode_reg == ST_RUN);
    wire in_lock = (mode_reg == ST_LOCKOUT);

    logic [`NUM_ZONES-1:0] zone_blk;
    always_comb begin
        for (int z = 0; z < `NUM_ZONES; z++) begin
            zone_blk[z] = |beam_s[z*`BEAMS_PER_ZONE +: `BEAMS_PER_ZONE];
        end
    end

    // beam 1 carries sync, so without it the other zones know nothing
    wire beam1_lost = in_align && beam_s[0];
    wire [`NUM_ZONES-1:0] zone_red_next =
        in_st ? {`NUM_ZONES{st_flash}} :
        beam1_lost ? `NUM_ZONES'(1) :
        (in_align || in_run) ? zone_blk : '0;
    wire [`NUM_ZONES-1:0] zone_green_next =
        (beam1_lost || !(in_align || in_run)) ? '0 : ~zone_blk;

    wire stat_green_next = safe_next && (!redres_reg || flash_reg);
    wire stat_red_next = in_st ? st_flash : in_lock ? flash_reg : !safe_next;
    wire emit_red_next = in_st ? st_flash : (in_lock && flash_reg);
    wire emit_green_next = in_run;

    // lockout error code has priority over a pending scan code show
    wire [4:0] cnt_tens = (blk_count >= 5'd10) ? 5'h1 : 5'h0;
    wire [4:0] cnt_ones = blk_count - (cnt_tens * 5'd10);
    wire seg_type hi_next =
        in_lock ? hex_seg(err_reg[7:4]) :
        (show_busy || in_st) ? 7'h00 :
        hex_seg(cnt_tens[3:0]);
    wire seg_type lo_next =
        in_lock ? hex_seg(err_reg[3:0]) :
        (show_busy || in_st) ? (show_lit ? hex_seg(scan_reg) : 7'h00) :
        hex_seg(cnt_ones[3:0]);

    always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            o_emit_red <= 1'b0;
            o_emit_green <= 1'b0;
            o_status_red <= 1'b0;
            o_status_green <= 1'b0;
            o_reset_lamp <= 1'b0;
            o_zone_red <= '0;
            o_zone_green <= '0;
            o_seg_hi <= 7'h00;
            o_seg_lo <= 7'h00;
        end else begin
            o_emit_red <= emit_red_next;
            o_emit_green <= emit_green_next;
            o_status_red <= stat_red_next;
            o_status_green <= stat_green_next;
            o_reset_lamp <= in_run;
            o_zone_red <= zone_red_next;
            o_zone_green <= zone_green_next;
            o_seg_hi <= hi_next;
            o_seg_lo <= lo_next;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!rst_sync_n);

    chk_pair_equal: assert property (
        o_safety_output_pair[0] == o_safety_output_pair[1])
        else $error("safety channels disagree");
    chk_block_trip: assert property (
        in_run && blk_any |=> o_safety_output_pair == 2'h0)
        else $error("outputs on while a beam is blocked");
    chk_auto_restore: assert property (
        in_run && !blk_any && !fault_s |=> o_safety_output_pair == 2'h3 && !o_status_red &&
        (o_status_green || $past(redres_reg)))
        else $error("outputs not restored on clear");
    chk_lockout_hold: assert property (
        in_lock |=> in_lock [*3])
        else $error("lockout left without power cycle");
    chk_fault_lock: assert property (
        (in_run || in_align) && fault_s |=> in_lock ##1 o_safety_output_pair == 2'h0)
        else $error("fault did not lock out");
    chk_run_entry: assert property (
        in_align && sync_s && !blk_any && !fault_s |=> in_run ##1 o_reset_lamp)
        else $error("aligned curtain did not enter run");
    chk_selftest_hold: assert property (
        in_st && !st_done |=> in_st && o_safety_output_pair == 2'h0)
        else $error("operation began before self-test end");
    chk_beam1_zones: assert property (
        beam1_lost |=> o_zone_red == `NUM_ZONES'(1) && o_zone_green == '0)
        else $error("zone lamps wrong with beam 1 blocked");
    chk_lockout_lamps: assert property (
        in_lock ##1 in_lock |-> !o_reset_lamp && o_zone_red == '0 && o_zone_green == '0)
        else $error("lamps lit during lockout");
    chk_amber_run: assert property (
        ##1 o_reset_lamp == $past(in_run))
        else $error("amber lamp does not follow run mode");

    cov_run: cover property (in_align ##1 in_run);
    cov_trip: cover property (in_run && safe_on_reg ##1 !safe_on_reg);
    cov_lock: cover property (in_run ##1 in_lock);
    cov_redres: cover property (in_run && redres_reg && safe_on_reg && !flash_reg);
endmodule

// *** lc_defines.svh ***
// constants of the light curtain mode controller
`ifndef LC_DEFINES_SVH
`define LC_DEFINES_SVH

// ****************************************
// clock and timing
// ****************************************
`define CLK_HZ 10000000
`define FLASH_HALF_MS 250
`define SELFTEST_MS 100
`define DIGIT_MS 400
`define SHOW_PHASES 3'h6

// ****************************************
// geometry
// ****************************************
`define NUM_BEAMS 16
`define NUM_ZONES 8
`define BEAMS_PER_ZONE 2

// ****************************************
// register map and fields
// ****************************************
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_ERR 4'h8
`define CTRL_REDRES_BIT 0
`define CTRL_SCAN_LSB 4
`define CTRL_SCAN_W 4
`define SCAN_RESET 4'h1

`endif

// *** lc_types_pkg.sv ***
// types of the light curtain mode controller
package lc_types_pkg;
    typedef enum logic [1:0] {ST_SELFTEST, ST_ALIGN, ST_RUN, ST_LOCKOUT} mode_type;
    typedef logic [6:0] seg_type;
endpackage

// *** scan_code_show.sv ***
// sequencer that flashes the scan code a fixed number of times
`include "lc_defines.svh"
module scan_code_show #(
    parameter int DIGIT_CYCLES = 4000000
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_sync_n,
    // control
    input wire logic i_start,
    // state
    output logic o_busy,
    output logic o_lit
);
    logic [2:0] phase_reg;
    logic [31:0] cnt_reg;
    wire last_cnt = (cnt_reg == 32'(DIGIT_CYCLES - 1));
    wire last_phase = (phase_reg == `SHOW_PHASES);

    always_ff @(posedge i_core_clk or negedge i_rst_sync_n) begin
        if (!i_rst_sync_n) begin
            phase_reg <= 3'h0;
            cnt_reg <= 32'h0;
        end else if (i_start) begin
            // a restart during a show begins again from the first flash
            phase_reg <= 3'h1;
            cnt_reg <= 32'h0;
        end else if (phase_reg != 3'h0) begin
            cnt_reg <= last_cnt ? 32'h0 : cnt_reg + 32'h1;
            if (last_cnt) begin
                phase_reg <= last_phase ? 3'h0 : phase_reg + 3'h1;
            end
        end
    end

    // odd phases lit, even phases dark: three separate flashes
    assign o_busy = (phase_reg != 3'h0);
    assign o_lit = phase_reg[0];
endmodule

// *** far_side_model.sv ***
// far side of the receiver: emitter light, sync pattern and fault source
module far_side_model (
    // clock
    input wire logic i_core_clk,
    // scene set by the bench
    input wire logic i_emit_on,
    input wire logic [15:0] i_obstruct,
    input wire logic i_fault_on,
    input wire logic [7:0] i_code,
    // lines into the receiver
    output logic [15:0] o_beam_blocked,
    output logic o_sync_valid,
    output logic o_fault,
    output logic [7:0] o_fault_code
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] idle_code = 8'hA5;
    // without emitter light every beam reads blocked
    assign o_beam_blocked = i_obstruct | {16{~i_emit_on}};
    // sync rides on beam 1 only, so blocking it loses sync
    assign o_sync_valid = i_emit_on & ~i_obstruct[0];
    assign o_fault = i_fault_on;
    // code lines change every cycle outside a fault to catch a late capture
    always @(posedge i_core_clk) begin
        idle_code <= ~idle_code + 8'h01;
    end
    assign o_fault_code = i_fault_on ? i_code : idle_code;
endmodule

// *** tb.sv ***
// self-checking bench of the light curtain mode controller
`include "lc_defines.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("FAIL %0t got %0h exp %0h", $time, got, exp); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lc_types_pkg::*;
    localparam int FL = 4;
    localparam int ST = 20;
    localparam int DG = 3;
    // segment patterns a..g on bits 0..6, active high
    localparam logic [6:0] SEG_TAB [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D,
        7'h7D, 7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [`NUM_BEAMS-1:0] beams;
    logic sync_v, flt;
    logic [7:0] fcode;
    logic emit_on = 1'b0;
    logic [15:0] obstruct = 16'h0;
    logic fault_on = 1'b0;
    logic [7:0] code = 8'h00;
    logic [1:0] o_safety_output_pair;
    logic o_emit_red, o_emit_green, o_status_red, o_status_green, o_reset_lamp;
    logic [`NUM_ZONES-1:0] o_zone_red, o_zone_green;
    seg_type o_seg_hi, o_seg_lo;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    // reference model state
    int m_mode = 0;
    int m_redres = 0;
    int n, g, r;
    logic [31:0] rd;

    always #50 i_core_clk = ~i_core_clk;

    far_side_model far_side_model_inst (.i_core_clk(i_core_clk), .i_emit_on(emit_on),
        .i_obstruct(obstruct), .i_fault_on(fault_on), .i_code(code), .o_beam_blocked(beams),
        .o_sync_valid(sync_v), .o_fault(flt), .o_fault_code(fcode));

    light_curtain_mode_control #(.FLASH_CYCLES(FL), .SELFTEST_CYCLES(ST), .DIGIT_CYCLES(DG))
        light_curtain_mode_control_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_beam_blocked(beams), .i_sync_valid(sync_v), .i_fault(flt), .i_fault_code(fcode),
        .o_safety_output_pair(o_safety_output_pair), .o_emit_red(o_emit_red),
        .o_emit_green(o_emit_green), .o_status_red(o_status_red),
        .o_status_green(o_status_green), .o_reset_lamp(o_reset_lamp),
        .o_zone_red(o_zone_red), .o_zone_green(o_zone_green), .o_seg_hi(o_seg_hi),
        .o_seg_lo(o_seg_lo));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ceiling well above the roughly 400 cycles the tests need
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles >= 6000) begin
            failures++;
            $display("FAIL %0t run did not finish", $time);
            stop_test();
        end
    end

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    function automatic logic [7:0] zone_or(input logic [15:0] b);
        logic [7:0] z;
        for (int i = 0; i < 8; i++) begin
            z[i] = b[2*i] | b[2*i+1];
        end
        return z;
    endfunction

    // counts separate lit episodes of the low digit with the high digit blank
    task automatic show_count(output int cnt);
        logic lit, prev;
        cnt = 0;
        prev = 1'b0;
        repeat (6*DG+6) begin
            @(posedge i_core_clk);
            #1;
            lit = (o_seg_hi === 7'h00) && ((|o_seg_lo) === 1'b1);
            if (lit && !prev) cnt++;
            prev = lit;
        end
    endtask

    task automatic flash_seen(output int gc, output int rc);
        gc = 0;
        rc = 0;
        repeat (4*FL) begin
            @(posedge i_core_clk);
            #1;
            gc += (o_status_green === 1'b1);
            rc += (o_status_red === 1'b1);
        end
    endtask

    task automatic check_state();
        logic [7:0] zb;
        logic on;
        int cnt;
        zb = zone_or(beams);
        cnt = $countones(beams);
        on = (m_mode == 2) && (beams == 16'h0);
        `CHK(o_safety_output_pair, {on, on})
        `CHK(o_reset_lamp, 1'(m_mode == 2))
        `CHK(o_emit_green, 1'(m_mode == 2))
        if (m_mode == 3) begin
            `CHK({o_zone_red, o_zone_green}, 16'h0)
        end else if (m_mode == 1 && beams[0]) begin
            `CHK({o_zone_red, o_zone_green}, 16'h0100)
        end else begin
            `CHK({o_zone_red, o_zone_green}, {zb, ~zb})
        end
        if (m_mode != 3) begin
            `CHK(o_status_red, ~on)
            if (m_redres == 0) `CHK(o_status_green, on)
        end
        if (m_mode == 3) begin
            `CHK({o_seg_hi, o_seg_lo}, {SEG_TAB[code[7:4]], SEG_TAB[code[3:0]]})
        end else begin
            `CHK({o_seg_hi, o_seg_lo}, {SEG_TAB[cnt / 10], SEG_TAB[cnt % 10]})
        end
        reg_read(`REG_STATUS, rd);
        `CHK(rd & 32'h1F07, {19'h0, 5'($countones(beams)), 5'h0, on, 2'(m_mode)})
    endtask

    task automatic settle();
        repeat (6) @(posedge i_core_clk);
        #1;
        if (m_mode != 3 && flt) m_mode = 3;
        else if (m_mode == 1 && sync_v && beams == 16'h0) m_mode = 2;
        check_state();
    endtask

    task automatic power_up();
        @(posedge i_core_clk);
        i_rstn <= 1'b0;
        repeat (8) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        m_mode = 0;
        m_redres = 0;
        repeat (3) @(posedge i_core_clk);
        #1;
        `CHK(o_safety_output_pair, 2'b00)
        `CHK({o_reset_lamp, o_emit_green}, 2'b00)
        `CHK(o_emit_red, 1'b1)
        show_count(n);
        `CHK(n, 3)
        repeat (ST) @(posedge i_core_clk);
        m_mode = flt ? 3 : 1;
        settle();
    endtask

    initial begin
        void'($urandom(32'hc983));
        power_up();
        $display("test power-up with no emitter done"); // beam 1 dark: align, zone 1 red
        @(posedge i_core_clk);
        emit_on <= 1'b1;
        obstruct <= 16'h0F0;
        settle();
        @(posedge i_core_clk);
        obstruct <= 16'h0;
        settle();
        `CHK(rd[1:0], 2'h2)
        $display("test alignment to run done");
        repeat (6) begin
            @(posedge i_core_clk);
            obstruct <= 16'($urandom);
            settle();
            @(posedge i_core_clk);
            obstruct <= 16'h0;
            settle();
        end
        $display("test run blocking done");
        reg_read(`REG_CTRL, rd);
        `CHK(rd, 32'h10)
        reg_write(`REG_STATUS, 32'hFFFF_FFFF);
        reg_read(4'hC, rd);
        `CHK(rd, 32'h0)
        check_state();
        reg_write(`REG_CTRL, 32'h31);
        m_redres = 1;
        show_count(n);
        `CHK(n, 3)
        reg_read(`REG_CTRL, rd);
        `CHK(rd, 32'h31)
        flash_seen(g, r);
        `CHK({g > 0, g < 4*FL, r == 0}, 3'b111)
        reg_write(`REG_CTRL, 32'h31);
        show_count(n);
        `CHK(n, 0)
        reg_write(`REG_CTRL, 32'h10);
        m_redres = 0;
        show_count(n);
        `CHK(n, 3)
        $display("test registers done");
        @(posedge i_core_clk);
        fault_on <= 1'b1;
        code <= 8'($urandom);
        settle();
        reg_read(`REG_ERR, rd);
        `CHK(rd[7:0], code)
        flash_seen(g, r);
        `CHK({r > 0, r < 4*FL, g == 0}, 3'b111)
        @(posedge i_core_clk);
        fault_on <= 1'b0;
        settle();
        `CHK(rd[1:0], 2'h3)
        $display("test run fault lockout done");
        @(posedge i_core_clk);
        fault_on <= 1'b1;
        power_up();
        `CHK(rd[1:0], 2'h3)
        $display("test power-up fault done");
        stop_test();
    end
endmodule
